// file: src/absd_pkg.sv
// constants and types for the analog bus strobe decoder
package absd_pkg;
    // converter clock rate and request-to-enable delay
    localparam int unsigned CONV_CLK_MHZ = 1;
    localparam int unsigned ENABLE_DELAY_US = 2;
    localparam logic [2:0] ENABLE_DELAY_TICKS = 3'(ENABLE_DELAY_US * CONV_CLK_MHZ);
    // reset and idle values
    localparam logic [7:0] BUS_IDLE = 8'hFF;
    localparam logic [7:0] SEL_IDLE_N = 8'hFF;
    localparam logic [2:0] TICK_RESET = 3'h0;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    // synchroniser reset holds both decoder enables inactive, so no select pulses out of reset
    localparam logic [31:0] PIN_SYNC_RESET = 32'h0000_00C0;
    // decoder B bits that leave the register active high: the two counter loads
    localparam logic [7:0] LOAD_ACTIVE_HIGH = 8'h30;
    // positions in the local decoder outputs
    localparam int unsigned LA_KBD_SCAN = 0;
    localparam int unsigned LA_DAC_U1 = 1;
    localparam int unsigned LA_DAC1 = 2;
    localparam int unsigned LA_DAC2 = 3;
    localparam int unsigned LA_DAC3 = 4;
    localparam int unsigned LA_TIMER = 6;
    localparam int unsigned LA_CONV_REG1 = 7;
    localparam int unsigned LB_KBD_SENSE = 0;
    localparam int unsigned LB_IRQ_PRIO = 1;
    localparam int unsigned LB_CONV_DATA1 = 2;
    localparam int unsigned LB_DAC_DATA0 = 3;
    localparam int unsigned LB_CNT_LD0 = 4;
    localparam int unsigned LB_CNT_LD1 = 5;
    localparam int unsigned LB_ROTARY = 6;
    localparam int unsigned LB_CONV_REG0 = 7;

    // remote assembly addressed by a write cycle
    typedef enum logic [1:0] {
        ABSD_RF   = 2'b00,
        ABSD_FC   = 2'b01,
        ABSD_IF   = 2'b10,
        ABSD_LOG  = 2'b11
    } absd_board_t;

    typedef enum logic [1:0] {
        ABSD_IDLE   = 2'b00,
        ABSD_WAIT   = 2'b01,
        ABSD_ACTIVE = 2'b10,
        ABSD_DONE   = 2'b11
    } absd_state_t;
endpackage : absd_pkg

// file: src/absd_strobe_decoder.sv
// analog bus strobe timing, remote strobe decode and local select decoders
`timescale 1ns/1ps
// Summary of operation
// - separate active-low strobe per remote board
// - frequency board strobe carries extra qualifier
// - decoder enable low 1 to 2 us after request
// - delay counted on 1 MHz converter clock
// - strobe pulses only on a controller write
// - drive address and data lines, idle high
// - decoder A: address bits 3..1, seven selects (code 5 has no output)
// - decoder B: address bits 2..0, eight selects
module absd_strobe_decoder
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // controller side, asynchronous pins
    input  wire logic                 analog_bus_request,
    input  wire logic                 converter_clock_1mhz,
    input  wire absd_pkg::absd_board_t board_select,
    input  wire logic [7:0]           cpu_addr,
    input  wire logic [7:0]           cpu_data,
    // local address and decoder enables
    input  wire logic                 local_addr_bit0,
    input  wire logic                 local_addr_bit1,
    input  wire logic                 local_addr_bit2,
    input  wire logic                 local_addr_bit3,
    input  wire logic                 local_dec_a_en_n,
    input  wire logic                 local_dec_b_en_n,
    // remote cable
    output logic [7:0]                remote_addr,
    output logic [7:0]                remote_data,
    output logic                      remote_decode_en_n,
    output logic                      rf_board_strobe_n,
    output logic                      rf_board_strobe_alt_n,
    output logic                      freq_ctrl_board_strobe_n,
    output logic                      freq_ctrl_board_strobe_alt_n,
    output logic                      if_board_strobe_n,
    output logic                      if_board_strobe_alt_n,
    output logic                      log_amp_strobe_n,
    output logic                      log_amp_strobe_alt_n,
    output logic                      freq_ctrl_qualifier_n,
    // local selects, decoder A
    output logic                      keyboard_scan_sel_n,
    output logic                      dac_u_one_sel_n,
    output logic                      dac_one_sel_n,
    output logic                      dac_two_sel_n,
    output logic                      dac_three_sel_n,
    output logic                      timer_sel_n,
    output logic                      converter_reg_one_sel_n,
    // local selects, decoder B
    output logic                      keyboard_sense_sel_n,
    output logic                      irq_priority_sel_n,
    output logic                      converter_data_one_sel_n,
    output logic                      dac_data_zero_sel_n,
    output logic                      counter_load_zero,
    output logic                      counter_load_one,
    output logic                      rotary_encoder_read_n,
    output logic                      converter_reg_zero_sel_n
);
    import absd_pkg::*;

    // active-low one-hot of a 3-bit code, all high when disabled
    function automatic logic [7:0] absd_dec3(input logic [2:0] code, input logic en_n);
        logic [7:0] sel;
        sel = SEL_IDLE_N;
        if (!en_n)
        begin
            sel[code] = 1'b0;
        end
        return sel;
    endfunction : absd_dec3

    // two-flop synchronisers for every pin input
    localparam int unsigned NSYNC = 32;
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync1_next;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] sync2_next;

    assign pins = {analog_bus_request, converter_clock_1mhz, board_select, cpu_addr, cpu_data,
                   local_addr_bit3, local_addr_bit2, local_addr_bit1, local_addr_bit0,
                   local_dec_a_en_n, local_dec_b_en_n, 6'h00};

    always_comb
    begin
        sync1_next = pins;
        sync2_next = sync1_reg;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= PIN_SYNC_RESET;
            sync2_reg <= PIN_SYNC_RESET;
        end
        else
        begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    logic        req_s;
    logic        cclk_s;
    absd_board_t board_s;
    logic [7:0]  addr_s;
    logic [7:0]  data_s;
    logic [3:0]  laddr_s;
    logic        dec_a_en_n_s;
    logic        dec_b_en_n_s;

    assign req_s        = sync2_reg[31];
    assign cclk_s       = sync2_reg[30];
    assign board_s      = absd_board_t'(sync2_reg[29:28]);
    assign addr_s       = sync2_reg[27:20];
    assign data_s       = sync2_reg[19:12];
    assign laddr_s      = sync2_reg[11:8];
    assign dec_a_en_n_s = sync2_reg[7];
    assign dec_b_en_n_s = sync2_reg[6];

    // edge history, taken only from the second synchroniser stage, registered with the sequencer
    logic [1:0] hist_reg;
    logic [1:0] hist_next;
    logic       req_rise;
    logic       cclk_rise;
    assign req_rise  = req_s & ~hist_reg[1];
    assign cclk_rise = cclk_s & ~hist_reg[0];

    // cycle sequencer: wait for converter ticks, then open the decoder
    absd_state_t state_reg;
    absd_state_t state_next;
    logic [2:0]  tick_reg;
    logic [2:0]  tick_next;
    absd_board_t board_reg;
    absd_board_t board_next;
    logic [7:0]  addr_reg;
    logic [7:0]  addr_next;
    logic [7:0]  data_reg;
    logic [7:0]  data_next;

    always_comb
    begin
        state_next = state_reg;
        tick_next  = tick_reg;
        board_next = board_reg;
        addr_next  = addr_reg;
        data_next  = data_reg;
        hist_next  = {req_s, cclk_s};
        case (state_reg)
            ABSD_IDLE:
            begin
                addr_next = BUS_IDLE;
                data_next = BUS_IDLE;
                if (req_rise)
                begin
                    state_next = ABSD_WAIT;
                    tick_next  = TICK_RESET;
                    board_next = board_s;
                    addr_next  = addr_s;
                    data_next  = data_s;
                end
            end
            ABSD_WAIT:
            begin
                // a stopped converter clock holds the cycle here, never strobing early
                if (!req_s)
                begin
                    state_next = ABSD_IDLE;
                end
                else if (cclk_rise)
                begin
                    tick_next = tick_reg + 3'h1;
                    if (tick_reg + 3'h1 >= ENABLE_DELAY_TICKS)
                    begin
                        state_next = ABSD_ACTIVE;
                    end
                end
            end
            ABSD_ACTIVE:
            begin
                if (!req_s)
                begin
                    state_next = ABSD_DONE;
                end
            end
            ABSD_DONE:
            begin
                // lines stay one cycle past the strobe edge for hold at the far end
                state_next = ABSD_IDLE;
                addr_next  = BUS_IDLE;
                data_next  = BUS_IDLE;
            end
            default:
            begin
                state_next = ABSD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ABSD_IDLE;
            tick_reg  <= TICK_RESET;
            board_reg <= ABSD_RF;
            addr_reg  <= BUS_IDLE;
            data_reg  <= BUS_IDLE;
            hist_reg  <= SYNC_RESET;
        end
        else
        begin
            state_reg <= state_next;
            tick_reg  <= tick_next;
            board_reg <= board_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
            hist_reg  <= hist_next;
        end
    end

    // output registers: remote strobes and both local decoders
    logic [3:0] rstb_reg;
    logic [3:0] rstb_next;
    logic [7:0] rsel;
    logic       en_n_reg;
    logic       en_n_next;
    logic       qual_n_reg;
    logic       qual_n_next;
    logic [7:0] dec_a_reg;
    logic [7:0] dec_a_next;
    logic [7:0] dec_b_reg;
    logic [7:0] dec_b_next;

    always_comb
    begin
        en_n_next   = (state_next != ABSD_ACTIVE);
        rsel        = absd_dec3({1'b0, board_next}, en_n_next);
        rstb_next   = rsel[3:0];
        qual_n_next = !((state_next == ABSD_WAIT || state_next == ABSD_ACTIVE)
                        && board_next == ABSD_FC);
        dec_a_next  = absd_dec3(laddr_s[3:1], dec_a_en_n_s);
        dec_b_next  = absd_dec3(laddr_s[2:0], dec_b_en_n_s) ^ LOAD_ACTIVE_HIGH;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rstb_reg   <= SEL_IDLE_N[3:0];
            en_n_reg   <= 1'b1;
            qual_n_reg <= 1'b1;
            dec_a_reg  <= SEL_IDLE_N;
            dec_b_reg  <= SEL_IDLE_N ^ LOAD_ACTIVE_HIGH;
        end
        else
        begin
            rstb_reg   <= rstb_next;
            en_n_reg   <= en_n_next;
            qual_n_reg <= qual_n_next;
            dec_a_reg  <= dec_a_next;
            dec_b_reg  <= dec_b_next;
        end
    end

    assign remote_addr                  = addr_reg;
    assign remote_data                  = data_reg;
    assign remote_decode_en_n           = en_n_reg;
    assign rf_board_strobe_n            = rstb_reg[ABSD_RF];
    assign rf_board_strobe_alt_n        = rstb_reg[ABSD_RF];
    assign freq_ctrl_board_strobe_n     = rstb_reg[ABSD_FC];
    assign freq_ctrl_board_strobe_alt_n = rstb_reg[ABSD_FC];
    assign if_board_strobe_n            = rstb_reg[ABSD_IF];
    assign if_board_strobe_alt_n        = rstb_reg[ABSD_IF];
    assign log_amp_strobe_n             = rstb_reg[ABSD_LOG];
    assign log_amp_strobe_alt_n         = rstb_reg[ABSD_LOG];
    assign freq_ctrl_qualifier_n        = qual_n_reg;

    assign keyboard_scan_sel_n      = dec_a_reg[LA_KBD_SCAN];
    assign dac_u_one_sel_n          = dec_a_reg[LA_DAC_U1];
    assign dac_one_sel_n            = dec_a_reg[LA_DAC1];
    assign dac_two_sel_n            = dec_a_reg[LA_DAC2];
    assign dac_three_sel_n          = dec_a_reg[LA_DAC3];
    assign timer_sel_n              = dec_a_reg[LA_TIMER];
    assign converter_reg_one_sel_n  = dec_a_reg[LA_CONV_REG1];

    assign keyboard_sense_sel_n     = dec_b_reg[LB_KBD_SENSE];
    assign irq_priority_sel_n       = dec_b_reg[LB_IRQ_PRIO];
    assign converter_data_one_sel_n = dec_b_reg[LB_CONV_DATA1];
    assign dac_data_zero_sel_n      = dec_b_reg[LB_DAC_DATA0];
    // counter loads are flipped to active high before the register, so pins come from flops
    assign counter_load_zero        = dec_b_reg[LB_CNT_LD0];
    assign counter_load_one         = dec_b_reg[LB_CNT_LD1];
    assign rotary_encoder_read_n    = dec_b_reg[LB_ROTARY];
    assign converter_reg_zero_sel_n = dec_b_reg[LB_CONV_REG0];
endmodule : absd_strobe_decoder

// file: test/absd_strobe_decoder_checker.sv
// port checker for the analog bus strobe decoder
`timescale 1ns/1ps
module absd_strobe_decoder_checker
(
    // clock, reset and request
    input wire logic       ref_clk, rst_n, analog_bus_request,
    // local decoder inputs
    input wire logic       local_addr_bit0, local_addr_bit1, local_addr_bit2, local_addr_bit3,
    input wire logic       local_dec_a_en_n, local_dec_b_en_n,
    // remote cable
    input wire logic [7:0] remote_addr, remote_data,
    input wire logic       remote_decode_en_n, freq_ctrl_qualifier_n, rf_board_strobe_n,
    input wire logic       freq_ctrl_board_strobe_n, if_board_strobe_n, log_amp_strobe_n,
    // local selects
    input wire logic       keyboard_scan_sel_n, dac_u_one_sel_n, dac_one_sel_n, dac_two_sel_n,
    input wire logic       dac_three_sel_n, timer_sel_n, converter_reg_one_sel_n,
    input wire logic       keyboard_sense_sel_n, irq_priority_sel_n, converter_data_one_sel_n,
    input wire logic       dac_data_zero_sel_n, counter_load_zero, counter_load_one,
    input wire logic       rotary_encoder_read_n, converter_reg_zero_sel_n
);
    logic [3:0] stb_n;
    logic [7:0] sel_a, sel_b, exp_a, exp_b;
    logic [9:0] cnt_reg, cnt_next;
    assign stb_n = {log_amp_strobe_n, if_board_strobe_n, freq_ctrl_board_strobe_n,
                    rf_board_strobe_n};
    assign sel_a = {converter_reg_one_sel_n, timer_sel_n, 1'b1, dac_three_sel_n,
                    dac_two_sel_n, dac_one_sel_n, dac_u_one_sel_n, keyboard_scan_sel_n};
    // counter loads are active high, folded to low-active for one compare
    assign sel_b = {converter_reg_zero_sel_n, rotary_encoder_read_n, ~counter_load_one,
                    ~counter_load_zero, dac_data_zero_sel_n, converter_data_one_sel_n,
                    irq_priority_sel_n, keyboard_sense_sel_n};
    assign exp_a = local_dec_a_en_n ? 8'hFF :
        (~(8'h01 << {local_addr_bit3, local_addr_bit2, local_addr_bit1}) | 8'h20);
    assign exp_b = local_dec_b_en_n ? 8'hFF :
        ~(8'h01 << {local_addr_bit2, local_addr_bit1, local_addr_bit0});
    // cycles the request pin has been high, saturating
    always_comb
    begin
        cnt_next = 10'h000;
        if (analog_bus_request)
            cnt_next = (cnt_reg == 10'h3FF) ? cnt_reg : cnt_reg + 10'h001;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cnt_reg <= 10'h000;
        else
            cnt_reg <= cnt_next;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_a_steady;
        $stable({local_dec_a_en_n, local_addr_bit3, local_addr_bit2, local_addr_bit1}) [*4];
    endsequence
    sequence s_b_steady;
        $stable({local_dec_b_en_n, local_addr_bit2, local_addr_bit1, local_addr_bit0}) [*4];
    endsequence
    sequence s_idle;
        !analog_bus_request [*8];
    endsequence
    chk_strobe_single: assert property ($onehot0(~stb_n))
        else $error("more than one remote strobe low");
    chk_fc_qualifier: assert property (!freq_ctrl_board_strobe_n |-> !freq_ctrl_qualifier_n)
        else $error("frequency strobe without qualifier");
    chk_enable_early: assert property ($fell(remote_decode_en_n) |-> cnt_reg >= 10'h0C8)
        else $error("decode enable came too early");
    chk_enable_late: assert property (cnt_reg == 10'h1A4 |-> !remote_decode_en_n)
        else $error("decode enable came too late");
    chk_strobe_enabled: assert property (stb_n != 4'hF |-> !remote_decode_en_n)
        else $error("strobe low while decode disabled");
    chk_strobe_write: assert property ($fell(&stb_n) |-> analog_bus_request)
        else $error("strobe without a write cycle");
    chk_bus_idle: assert property (s_idle |-> {remote_addr, remote_data} == 16'hFFFF)
        else $error("remote lines not idle high");
    chk_dec_a_map: assert property (s_a_steady |-> sel_a == exp_a)
        else $error("decoder A select mismatch");
    chk_dec_b_map: assert property (s_b_steady |-> sel_b == exp_b)
        else $error("decoder B select mismatch");
endmodule : absd_strobe_decoder_checker

// file: test/absd_ctrl_model.sv
// controller model issuing analog bus write cycles
`timescale 1ns/1ps
module absd_ctrl_model
(
    // clock
    input  wire logic             ref_clk,
    // analog bus pins
    output logic                  analog_bus_request,
    output logic                  converter_clock_1mhz,
    output absd_pkg::absd_board_t board_select,
    output logic [7:0]            cpu_addr,
    output logic [7:0]            cpu_data
);
    import absd_pkg::*;
    logic cclk_run = 1'b1;
    initial
    begin
        analog_bus_request = 1'b0;
        converter_clock_1mhz = 1'b0;
        board_select = ABSD_RF;
        cpu_addr = 8'h00;
        cpu_data = 8'h00;
        // odd offset keeps its phase unrelated to ref_clk
        #137;
        forever
            #500 converter_clock_1mhz = converter_clock_1mhz ^ cclk_run;
    end
    // one call per changed setting of a board
    task automatic begin_write(input absd_board_t b, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        board_select <= b;
        cpu_addr     <= a;
        cpu_data     <= d;
        @(posedge ref_clk);
        analog_bus_request <= 1'b1;
    endtask : begin_write
    task automatic end_write();
        @(posedge ref_clk);
        analog_bus_request <= 1'b0;
        repeat (6) @(posedge ref_clk);
        // released lines show the inverse, never a stale copy
        cpu_addr <= ~cpu_addr;
        cpu_data <= ~cpu_data;
        repeat (3) @(posedge ref_clk);
    endtask : end_write
endmodule : absd_ctrl_model

// file: test/absd_strobe_decoder_tb.sv
// self-checking testbench for the analog bus strobe decoder
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module absd_strobe_decoder_tb;
    import absd_pkg::*;
    logic        ref_clk, rst_n, analog_bus_request, converter_clock_1mhz, seen_strobe;
    absd_board_t board_select;
    logic [7:0]  cpu_addr, cpu_data, remote_addr, remote_data;
    logic        local_addr_bit0, local_addr_bit1, local_addr_bit2, local_addr_bit3;
    logic        local_dec_a_en_n, local_dec_b_en_n, remote_decode_en_n, freq_ctrl_qualifier_n;
    logic        rf_board_strobe_n, rf_board_strobe_alt_n, freq_ctrl_board_strobe_n;
    logic        freq_ctrl_board_strobe_alt_n, if_board_strobe_n, if_board_strobe_alt_n;
    logic        log_amp_strobe_n, log_amp_strobe_alt_n, keyboard_scan_sel_n, dac_u_one_sel_n;
    logic        dac_one_sel_n, dac_two_sel_n, dac_three_sel_n, timer_sel_n;
    logic        converter_reg_one_sel_n, keyboard_sense_sel_n, irq_priority_sel_n;
    logic        converter_data_one_sel_n, dac_data_zero_sel_n, counter_load_zero;
    logic        counter_load_one, rotary_encoder_read_n, converter_reg_zero_sel_n;
    int          n_errors = 0;
    int          n_checks = 0;
    wire [3:0] stb_n = {log_amp_strobe_n, if_board_strobe_n, freq_ctrl_board_strobe_n,
                        rf_board_strobe_n};
    wire [3:0] alt_n = {log_amp_strobe_alt_n, if_board_strobe_alt_n,
                        freq_ctrl_board_strobe_alt_n, rf_board_strobe_alt_n};
    wire [7:0] sel_a = {converter_reg_one_sel_n, timer_sel_n, 1'b1, dac_three_sel_n,
                        dac_two_sel_n, dac_one_sel_n, dac_u_one_sel_n, keyboard_scan_sel_n};
    wire [7:0] sel_b = {converter_reg_zero_sel_n, rotary_encoder_read_n, ~counter_load_one,
                        ~counter_load_zero, dac_data_zero_sel_n, converter_data_one_sel_n,
                        irq_priority_sel_n, keyboard_sense_sel_n};
    absd_ctrl_model ctrl_u (.*);
    absd_strobe_decoder dut_u (.*);
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (stb_n != 4'hF)
            seen_strobe <= 1'b1;
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic t_write(input absd_board_t b, input logic [7:0] a);
        int waited;
        waited = 0;
        ctrl_u.begin_write(b, a, ~a);
        while (remote_decode_en_n !== 1'b0 && waited < 600)
        begin
            @(posedge ref_clk);
            #1;
            waited++;
        end
        `CHK(waited >= 200 && waited <= 420, 1'b1)
        `CHK(stb_n, ~(4'h1 << b))
        `CHK(alt_n, ~(4'h1 << b))
        `CHK(freq_ctrl_qualifier_n, b != ABSD_FC)
        `CHK({remote_addr, remote_data}, {a, ~a})
        ctrl_u.end_write();
        #1;
        `CHK({stb_n, alt_n, remote_decode_en_n}, 9'h1FF)
        `CHK({remote_addr, remote_data, freq_ctrl_qualifier_n}, {BUS_IDLE, BUS_IDLE, 1'b1})
    endtask : t_write
    // request dropped inside the delay, or delay clock stopped: no strobe at all
    task automatic t_no_strobe(input logic run, input int hold);
        seen_strobe = 1'b0;
        ctrl_u.cclk_run = run;
        ctrl_u.begin_write(ABSD_IF, 8'h12, 8'h34);
        repeat (hold) @(posedge ref_clk);
        ctrl_u.end_write();
        repeat (500) @(posedge ref_clk);
        #1;
        `CHK(seen_strobe, 1'b0)
        ctrl_u.cclk_run = 1'b1;
    endtask : t_no_strobe
    task automatic t_local();
        for (int v = 0; v < 17; v++)
        begin
            @(posedge ref_clk);
            {local_addr_bit3, local_addr_bit2, local_addr_bit1, local_addr_bit0} <= 4'(v);
            local_dec_a_en_n <= (v == 16);
            local_dec_b_en_n <= v[3];
            repeat (4) @(posedge ref_clk);
            #1;
            `CHK(sel_a, (v == 16) ? SEL_IDLE_N : (~(8'h01 << v[3:1]) | 8'h20))
            `CHK(sel_b, v[3] ? SEL_IDLE_N : ~(8'h01 << v[2:0]))
        end
    endtask : t_local
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end
    initial
    begin
        rst_n = 1'b0;
        {local_addr_bit3, local_addr_bit2, local_addr_bit1, local_addr_bit0} = 4'h0;
        local_dec_a_en_n = 1'b1;
        local_dec_b_en_n = 1'b1;
        seen_strobe = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK({stb_n, sel_a, sel_b}, {4'hF, SEL_IDLE_N, SEL_IDLE_N})
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK({remote_addr, remote_data}, {BUS_IDLE, BUS_IDLE})
        `CHK({stb_n, sel_a}, {4'hF, SEL_IDLE_N})
        `CHK(sel_b, SEL_IDLE_N)
        `CHK({alt_n, remote_decode_en_n, freq_ctrl_qualifier_n}, 6'h3F)
        for (int i = 0; i < 4; i++)
            t_write(absd_board_t'(i), 8'(i * 85) ^ 8'h0F);
        t_no_strobe(1'b1, 150);
        t_no_strobe(1'b0, 400);
        t_write(ABSD_FC, 8'h00);
        t_local();
        conclude();
    end
endmodule : absd_strobe_decoder_tb
bind absd_strobe_decoder absd_strobe_decoder_checker chk_u (.*);
